// *** hdl/crs_core_regs.sv ***
// cpu architectural register set with apb access and stack port
// assumes stack memory returns read data in the cycle its read strobe is high
// What this block does
// RULE_01 - keep a 16-bit fetch pointer, high and low byte, at next instruction
// RULE_02 - during reset the fetch pointer holds FFFC
// RULE_03 - provide an 8-bit accumulator for transfer, storage and conditions
// RULE_04 - 8-bit stack index, updated automatically on calls and accepted interrupts
// RULE_05 - effective address is operand plus an index; indexes inc, dec, compare, transfer
// RULE_06 - 8-bit flag word, mask plus five flags, pushed and pulled whole
// RULE_07 - negative flag copies result bit 7
// RULE_08 - overflow set when signed add or subtract leaves -128..+127
// RULE_09 - decimal flag picks binary or decimal add and subtract
// RULE_10 - interrupt disable masks maskable requests; nmi always accepted
// RULE_11 - zero flag set on zero result, else cleared
// RULE_12 - carry from add carry-out, subtract no-borrow, shifts and rotates
// RULE_13 - flag bits set or cleared individually; other operations leave them
// RULE_14 - flag layout N7 V6 D3 I2 Z1 C0
// RULE_15 - push writes then decrements; pop increments then reads; page 1
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module crs_core_regs (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // interrupt requests
   input  wire logic        irq_req,
   input  wire logic        nmi_req,
   output logic             int_taken,
   // stack memory port
   output logic             stk_we,
   output logic             stk_re,
   output logic      [8:0]  stk_addr,
   output logic      [7:0]  stk_wdata,
   input  wire logic [7:0]  stk_rdata,
   // architectural view
   output logic      [15:0] fetch_ptr,
   output logic      [15:0] eff_addr
);
   typedef struct packed {
      logic [7:0]          acc;
      logic [7:0]          xr;
      logic [7:0]          yr;
      logic [7:0]          si;
      logic [15:0]         fp;
      logic [7:0]          flg;
      logic [15:0]         ea;
      logic [15:0]         tgt;
      logic                is_int;
      logic                nmi_prev;
      logic                nmi_pend;
      crs_pkg::crs_state_t st;
      logic [31:0]         rdata;
      logic                stk_we;
      logic                stk_re;
      logic [8:0]          stk_addr;
      logic [7:0]          stk_wd;
      logic                int_tk;
   } crs_regs_t;

   crs_regs_t r_ff;
   crs_regs_t nxt_r;

   // =====================================================
   // helpers
   // update negative and zero from a result
   function automatic logic [7:0] crs_nz(input logic [7:0] f, input logic [7:0] v);
      logic [7:0] o;
      o = f;
      o[crs_pkg::FLG_N] = v[7];                // [RULE_07]
      o[crs_pkg::FLG_Z] = (v == 8'h00);        // [RULE_11]
      return o;
   endfunction

   // mapped register address decode, for the error and write strobe
   function automatic logic crs_mapped(input logic [7:0] a);
      if (a == crs_pkg::ADR_ACC || a == crs_pkg::ADR_XR || a == crs_pkg::ADR_YR)
         return 1'b1;
      else if (a == crs_pkg::ADR_STK || a == crs_pkg::ADR_FETCH || a == crs_pkg::ADR_FLAG)
         return 1'b1;
      else if (a == crs_pkg::ADR_OPER || a == crs_pkg::ADR_EFF || a == crs_pkg::ADR_STAT)
         return 1'b1;
      else
         return 1'b0;
   endfunction

   logic op_wr;
   logic busy;
   logic fire;
   // an operation write waits while a push or pull sequence runs
   assign busy    = (r_ff.st != crs_pkg::ST_IDLE);
   assign op_wr   = psel && pwrite && (paddr == crs_pkg::ADR_OPER);
   assign pready  = !(op_wr && busy);
   assign pslverr = psel && penable && !crs_mapped(paddr);
   assign fire    = psel && penable && pready && pwrite && crs_mapped(paddr);

   // =====================================================
   // next state
   always_comb begin
      logic [7:0]  d;
      logic [8:0]  bin;
      logic [4:0]  lo;
      logic [4:0]  hi;
      logic        cin;
      logic [7:0]  f;
      crs_pkg::crs_op_t op;
      d   = pwdata[15:8];
      bin = 9'h000;
      lo  = 5'h00;
      hi  = 5'h00;
      cin = r_ff.flg[crs_pkg::FLG_C];
      f   = r_ff.flg;
      op  = crs_pkg::crs_op_t'(pwdata[4:0]);
      nxt_r = r_ff;
      nxt_r.stk_we   = 1'b0;
      nxt_r.stk_re   = 1'b0;
      nxt_r.int_tk   = 1'b0;
      nxt_r.nmi_prev = nmi_req;
      if (nmi_req && !r_ff.nmi_prev)
         nxt_r.nmi_pend = 1'b1;
      // read data captured in the setup phase
      if (psel && !penable && !pwrite) begin
         if (paddr == crs_pkg::ADR_ACC)
            nxt_r.rdata = {24'h000000, r_ff.acc};
         else if (paddr == crs_pkg::ADR_XR)
            nxt_r.rdata = {24'h000000, r_ff.xr};
         else if (paddr == crs_pkg::ADR_YR)
            nxt_r.rdata = {24'h000000, r_ff.yr};
         else if (paddr == crs_pkg::ADR_STK)
            nxt_r.rdata = {24'h000000, r_ff.si};
         else if (paddr == crs_pkg::ADR_FETCH)
            nxt_r.rdata = {16'h0000, r_ff.fp};
         else if (paddr == crs_pkg::ADR_FLAG)
            nxt_r.rdata = {24'h000000, r_ff.flg};
         else if (paddr == crs_pkg::ADR_EFF)
            nxt_r.rdata = {16'h0000, r_ff.ea};
         else if (paddr == crs_pkg::ADR_STAT)
            nxt_r.rdata = {27'h0000000, r_ff.nmi_pend, busy, r_ff.st};
         else
            nxt_r.rdata = 32'h00000000;
      end
      case (r_ff.st)
         crs_pkg::ST_IDLE: begin
            if (fire && paddr != crs_pkg::ADR_OPER) begin
               // direct register writes
               if (paddr == crs_pkg::ADR_ACC)
                  nxt_r.acc = pwdata[7:0];                       // [RULE_03]
               else if (paddr == crs_pkg::ADR_XR)
                  nxt_r.xr = pwdata[7:0];
               else if (paddr == crs_pkg::ADR_YR)
                  nxt_r.yr = pwdata[7:0];
               else if (paddr == crs_pkg::ADR_STK)
                  nxt_r.si = pwdata[7:0];
               else if (paddr == crs_pkg::ADR_FETCH)
                  nxt_r.fp = pwdata[15:0];                       // [RULE_01]
               else if (paddr == crs_pkg::ADR_FLAG)
                  nxt_r.flg = pwdata[7:0];
            end else if (fire) begin
               case (op)
                  crs_pkg::OP_ADC: begin
                     bin = {1'b0, r_ff.acc} + {1'b0, d} + {8'h00, cin};
                     f[crs_pkg::FLG_V] = ~(r_ff.acc[7] ^ d[7]) & (r_ff.acc[7] ^ bin[7]); // [RULE_08]
                     if (r_ff.flg[crs_pkg::FLG_D]) begin                 // [RULE_09]
                        lo = {1'b0, r_ff.acc[3:0]} + {1'b0, d[3:0]} + {4'h0, cin};
                        if (lo > 5'h09)
                           lo = lo + 5'h06;
                        hi = {1'b0, r_ff.acc[7:4]} + {1'b0, d[7:4]} + {4'h0, lo[4]};
                        if (hi > 5'h09)
                           hi = hi + 5'h06;
                        bin = {hi[4], hi[3:0], lo[3:0]};
                     end
                     f[crs_pkg::FLG_C] = bin[8];                          // [RULE_12]
                     nxt_r.acc = bin[7:0];
                     nxt_r.flg = crs_nz(f, bin[7:0]);
                  end
                  crs_pkg::OP_SBC: begin
                     bin = {1'b0, r_ff.acc} + {1'b0, ~d} + {8'h00, cin};
                     f[crs_pkg::FLG_V] = (r_ff.acc[7] ^ d[7]) & (r_ff.acc[7] ^ bin[7]); // [RULE_08]
                     if (r_ff.flg[crs_pkg::FLG_D]) begin                 // [RULE_09]
                        lo = {1'b0, r_ff.acc[3:0]} - {1'b0, d[3:0]} - {4'h0, ~cin};
                        hi = {1'b0, r_ff.acc[7:4]} - {1'b0, d[7:4]} - {4'h0, lo[4]};
                        if (lo[4])
                           lo = lo - 5'h06;
                        if (hi[4])
                           hi = hi - 5'h06;
                        bin = {bin[8], hi[3:0], lo[3:0]};
                     end
                     f[crs_pkg::FLG_C] = bin[8];                          // [RULE_12]
                     nxt_r.acc = bin[7:0];
                     nxt_r.flg = crs_nz(f, bin[7:0]);
                  end
                  crs_pkg::OP_LDA: begin
                     nxt_r.acc = d;
                     nxt_r.flg = crs_nz(f, d);
                  end
                  crs_pkg::OP_INX: begin
                     nxt_r.xr  = r_ff.xr + 8'h01;                         // [RULE_05]
                     nxt_r.flg = crs_nz(f, r_ff.xr + 8'h01);
                  end
                  crs_pkg::OP_DEX: begin
                     nxt_r.xr  = r_ff.xr - 8'h01;
                     nxt_r.flg = crs_nz(f, r_ff.xr - 8'h01);
                  end
                  crs_pkg::OP_INY: begin
                     nxt_r.yr  = r_ff.yr + 8'h01;
                     nxt_r.flg = crs_nz(f, r_ff.yr + 8'h01);
                  end
                  crs_pkg::OP_DEY: begin
                     nxt_r.yr  = r_ff.yr - 8'h01;
                     nxt_r.flg = crs_nz(f, r_ff.yr - 8'h01);
                  end
                  crs_pkg::OP_CPX: begin
                     f[crs_pkg::FLG_C] = (r_ff.xr >= d);                  // [RULE_12]
                     nxt_r.flg = crs_nz(f, r_ff.xr - d);                  // [RULE_05]
                  end
                  crs_pkg::OP_CPY: begin
                     f[crs_pkg::FLG_C] = (r_ff.yr >= d);
                     nxt_r.flg = crs_nz(f, r_ff.yr - d);
                  end
                  crs_pkg::OP_ASL: begin
                     f[crs_pkg::FLG_C] = r_ff.acc[7];                     // [RULE_12]
                     nxt_r.acc = {r_ff.acc[6:0], 1'b0};
                     nxt_r.flg = crs_nz(f, {r_ff.acc[6:0], 1'b0});
                  end
                  crs_pkg::OP_ROR: begin
                     f[crs_pkg::FLG_C] = r_ff.acc[0];
                     nxt_r.acc = {cin, r_ff.acc[7:1]};
                     nxt_r.flg = crs_nz(f, {cin, r_ff.acc[7:1]});
                  end
                  crs_pkg::OP_PSHF: begin
                     // write at the index, then step it down
                     nxt_r.stk_we   = 1'b1;                               // [RULE_15]
                     nxt_r.stk_addr = {crs_pkg::STK_PAGE, r_ff.si};
                     nxt_r.stk_wd   = r_ff.flg;                           // [RULE_06]
                     nxt_r.si       = r_ff.si - 8'h01;
                  end
                  crs_pkg::OP_PULF: begin
                     // step the index up, then read
                     nxt_r.si       = r_ff.si + 8'h01;                    // [RULE_15]
                     nxt_r.stk_re   = 1'b1;
                     nxt_r.stk_addr = {crs_pkg::STK_PAGE, r_ff.si + 8'h01};
                     nxt_r.st       = crs_pkg::ST_PULL;
                  end
                  crs_pkg::OP_CALL: begin
                     nxt_r.tgt    = pwdata[31:16];
                     nxt_r.is_int = 1'b0;
                     nxt_r.st     = crs_pkg::ST_PUSH_HI;                  // [RULE_04]
                  end
                  crs_pkg::OP_FSET: begin
                     // mask in [15:8], values in [23:16]
                     nxt_r.flg = (r_ff.flg & ~d) | (d & pwdata[23:16]);  // [RULE_13]
                  end
                  crs_pkg::OP_TAX: begin
                     nxt_r.xr  = r_ff.acc;
                     nxt_r.flg = crs_nz(f, r_ff.acc);
                  end
                  crs_pkg::OP_TAY: begin
                     nxt_r.yr  = r_ff.acc;
                     nxt_r.flg = crs_nz(f, r_ff.acc);
                  end
                  crs_pkg::OP_TXA: begin
                     nxt_r.acc = r_ff.xr;
                     nxt_r.flg = crs_nz(f, r_ff.xr);
                  end
                  crs_pkg::OP_TYA: begin
                     nxt_r.acc = r_ff.yr;
                     nxt_r.flg = crs_nz(f, r_ff.yr);
                  end
                  crs_pkg::OP_EAX:
                     nxt_r.ea = pwdata[31:16] + {8'h00, r_ff.xr};         // [RULE_05]
                  crs_pkg::OP_EAY:
                     nxt_r.ea = pwdata[31:16] + {8'h00, r_ff.yr};
                  crs_pkg::OP_TXS:
                     nxt_r.si = r_ff.xr;
                  crs_pkg::OP_STEP:
                     nxt_r.fp = r_ff.fp + {8'h00, d};                     // [RULE_01]
                  default: begin
                     // no flag change for anything else [RULE_13]
                     nxt_r.flg = r_ff.flg;
                  end
               endcase
            end else if (r_ff.nmi_pend || (irq_req && !r_ff.flg[crs_pkg::FLG_I])) begin
               // accept an interrupt; nmi ignores the mask [RULE_10]
               nxt_r.is_int = 1'b1;
               nxt_r.int_tk = 1'b1;
               nxt_r.tgt    = r_ff.nmi_pend ? crs_pkg::VEC_NMI : crs_pkg::VEC_IRQ;
               if (r_ff.nmi_pend && !(nmi_req && !r_ff.nmi_prev))
                  nxt_r.nmi_pend = 1'b0;
               nxt_r.st     = crs_pkg::ST_PUSH_HI;
            end
         end
         crs_pkg::ST_PUSH_HI: begin
            nxt_r.stk_we   = 1'b1;
            nxt_r.stk_addr = {crs_pkg::STK_PAGE, r_ff.si};
            nxt_r.stk_wd   = r_ff.fp[15:8];
            nxt_r.si       = r_ff.si - 8'h01;                             // [RULE_04]
            nxt_r.st       = crs_pkg::ST_PUSH_LO;
         end
         crs_pkg::ST_PUSH_LO: begin
            nxt_r.stk_we   = 1'b1;
            nxt_r.stk_addr = {crs_pkg::STK_PAGE, r_ff.si};
            nxt_r.stk_wd   = r_ff.fp[7:0];
            nxt_r.si       = r_ff.si - 8'h01;                             // [RULE_04]
            if (r_ff.is_int) begin
               nxt_r.st = crs_pkg::ST_PUSH_FLG;
            end else begin
               nxt_r.fp = r_ff.tgt;
               nxt_r.st = crs_pkg::ST_IDLE;
            end
         end
         crs_pkg::ST_PUSH_FLG: begin
            nxt_r.stk_we   = 1'b1;
            nxt_r.stk_addr = {crs_pkg::STK_PAGE, r_ff.si};
            nxt_r.stk_wd   = r_ff.flg;
            nxt_r.si       = r_ff.si - 8'h01;
            nxt_r.flg[crs_pkg::FLG_I] = 1'b1;
            nxt_r.fp       = r_ff.tgt;
            nxt_r.st       = crs_pkg::ST_IDLE;
         end
         crs_pkg::ST_PULL: begin
            nxt_r.flg = stk_rdata;                                        // [RULE_06]
            nxt_r.st  = crs_pkg::ST_IDLE;
         end
         default:
            nxt_r.st = crs_pkg::ST_IDLE;
      endcase
   end

   // =====================================================
   // state register; fetch pointer forced to FFFC in reset
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         r_ff     <= '0;
         r_ff.fp  <= crs_pkg::FETCH_RST;                                  // [RULE_02]
         r_ff.si  <= crs_pkg::STK_RST;
         r_ff.flg <= crs_pkg::FLAG_RST;                                   // [RULE_14]
         r_ff.st  <= crs_pkg::ST_IDLE;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // outputs from flops
   assign prdata    = r_ff.rdata;
   assign int_taken = r_ff.int_tk;
   assign stk_we    = r_ff.stk_we;
   assign stk_re    = r_ff.stk_re;
   assign stk_addr  = r_ff.stk_addr;
   assign stk_wdata = r_ff.stk_wd;
   assign fetch_ptr = r_ff.fp;
   assign eff_addr  = r_ff.ea;
endmodule
`default_nettype wire

// *** inc/crs_pkg.sv ***
// constants for the cpu register set: bus map, flag layout, reset values
// assumes a 32-bit apb master and a byte-wide stack memory outside
`default_nettype none
package crs_pkg;
   // =====================================================
   // apb map (byte addresses)
   localparam logic [7:0] ADR_ACC   = 8'h00;
   localparam logic [7:0] ADR_XR    = 8'h04;
   localparam logic [7:0] ADR_YR    = 8'h08;
   localparam logic [7:0] ADR_STK   = 8'h0C;
   localparam logic [7:0] ADR_FETCH = 8'h10;
   localparam logic [7:0] ADR_FLAG  = 8'h14;
   localparam logic [7:0] ADR_OPER  = 8'h18;
   localparam logic [7:0] ADR_EFF   = 8'h1C;
   localparam logic [7:0] ADR_STAT  = 8'h20;
   // =====================================================
   // flag word bit positions
   localparam int FLG_N = 7;
   localparam int FLG_V = 6;
   localparam int FLG_D = 3;
   localparam int FLG_I = 2;
   localparam int FLG_Z = 1;
   localparam int FLG_C = 0;
   // =====================================================
   // reset values and vectors
   localparam logic [15:0] FETCH_RST = 16'hFFFC;
   localparam logic [7:0]  STK_RST   = 8'hFF;
   localparam logic [7:0]  FLAG_RST  = 8'h34;
   localparam logic [15:0] VEC_NMI   = 16'hFFFA;
   localparam logic [15:0] VEC_IRQ   = 16'hFFFE;
   localparam logic        STK_PAGE  = 1'b1;
   // =====================================================
   // operation codes, oper register bits [4:0]
   typedef enum logic [4:0] {
      OP_NOP  = 5'h00, OP_ADC  = 5'h01, OP_SBC  = 5'h02, OP_LDA  = 5'h03,
      OP_INX  = 5'h04, OP_DEX  = 5'h05, OP_INY  = 5'h06, OP_DEY  = 5'h07,
      OP_CPX  = 5'h08, OP_CPY  = 5'h09, OP_ASL  = 5'h0A, OP_ROR  = 5'h0B,
      OP_PSHF = 5'h0C, OP_PULF = 5'h0D, OP_CALL = 5'h0E, OP_FSET = 5'h0F,
      OP_TAX  = 5'h10, OP_TAY  = 5'h11, OP_TXA  = 5'h12, OP_TYA  = 5'h13,
      OP_EAX  = 5'h14, OP_EAY  = 5'h15, OP_TXS  = 5'h16, OP_STEP = 5'h17
   } crs_op_t;
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_PUSH_HI = 3'b001, ST_PUSH_LO = 3'b010,
      ST_PUSH_FLG = 3'b011, ST_PULL = 3'b100
   } crs_state_t;
endpackage
`default_nettype wire

// *** tb/crs_regs_sva.sv ***
// port checker for crs_core_regs
// bound from the testbench top
`timescale 1ns/10ps
`default_nettype none
module crs_regs_sva (
   // clock, reset
   input wire logic        ref_clk,
   input wire logic        rst_b,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // interrupts
   input wire logic        irq_req,
   input wire logic        nmi_req,
   input wire logic        int_taken,
   // stack and view
   input wire logic        stk_we,
   input wire logic        stk_re,
   input wire logic [8:0]  stk_addr,
   input wire logic [7:0]  stk_wdata,
   input wire logic [7:0]  stk_rdata,
   input wire logic [15:0] fetch_ptr,
   input wire logic [15:0] eff_addr
);
   // =====================================================
   // assertions
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   ptr_reset_a: assert property ($rose(rst_b) |-> fetch_ptr == crs_pkg::FETCH_RST)
      else $error("fetch pointer not at reset value");
   fetch_read_a: assert property (psel && !penable && !pwrite && paddr == crs_pkg::ADR_FETCH
      |=> prdata == {16'h0000, $past(fetch_ptr)}) else $error("fetch pointer read wrong");
   stk_page_a: assert property (stk_we || stk_re |-> stk_addr[8] == crs_pkg::STK_PAGE)
      else $error("stack access off page one");
   push_down_a: assert property (stk_we && $past(stk_we) |-> stk_addr == $past(stk_addr) - 9'h001)
      else $error("push addresses not descending");
   int_vec_a: assert property (int_taken |-> ##3 (fetch_ptr == crs_pkg::VEC_NMI ||
      fetch_ptr == crs_pkg::VEC_IRQ)) else $error("no vector after interrupt");
   int_pulse_a: assert property (int_taken |=> !int_taken)
      else $error("interrupt accept not a pulse");
   pull_one_a: assert property (stk_re |=> !stk_re && !stk_we)
      else $error("pull strobe longer than one cycle");
   unmapped_err_a: assert property (psel && penable && paddr > crs_pkg::ADR_STAT |-> pslverr)
      else $error("unmapped access without error");
   zero_wait_a: assert property (psel && penable && paddr != crs_pkg::ADR_OPER |-> pready)
      else $error("register access stalled");
   // main scenarios seen
   cover property (int_taken);
   cover property (stk_re);
   cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// *** tb/crs_stack_mem.sv ***
// stack memory model on the far side of the register set
// assumes page 1 addressing; read data is combinational from the address
`timescale 1ns/10ps
`default_nettype none
module crs_stack_mem (
   // clock
   input  wire logic       ref_clk,
   // stack port
   input  wire logic       stk_we,
   input  wire logic       stk_re,
   input  wire logic [8:0] stk_addr,
   input  wire logic [7:0] stk_wdata,
   output logic      [7:0] stk_rdata
);
   // =====================================================
   // storage
   logic [7:0] mem_ff [256];
   logic [7:0] last_ff = 8'h00;
   // byte taken in the strobe cycle
   always @(posedge ref_clk) begin
      if (stk_we) mem_ff[stk_addr[7:0]] <= stk_wdata;
      if (stk_re) last_ff <= stk_rdata;
   end
   // data only valid while read strobe is high, scrambled otherwise
   assign stk_rdata = stk_re ? mem_ff[stk_addr[7:0]] : ~last_ff;
endmodule
`default_nettype wire

// *** tb/tb_crs_core_regs.sv ***
// self-checking bench for the cpu register set
// drives apb and interrupt pins; stack memory model on the far side
`timescale 1ns/10ps
`default_nettype none
module tb_crs_core_regs;
   logic        ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        irq_req = 1'b0, nmi_req = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, int_taken, stk_we, stk_re;
   logic [8:0]  stk_addr;
   logic [7:0]  stk_wdata, stk_rdata;
   logic [15:0] fetch_ptr, eff_addr;
   int          fail_count = 0, n_tests = 0, cyc = 0, n_int = 0;
   // =====================================================
   // design and partner
   crs_core_regs u_dut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .irq_req, .nmi_req, .int_taken, .stk_we, .stk_re,
      .stk_addr, .stk_wdata, .stk_rdata, .fetch_ptr, .eff_addr);
   crs_stack_mem u_mem (.ref_clk, .stk_we, .stk_re, .stk_addr, .stk_wdata, .stk_rdata);
   // clock, timeout and accept counter
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (int_taken === 1'b1) n_int <= n_int + 1;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   // =====================================================
   // shared tasks
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int   n;
      logic rdy;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // settled values, as the slave shows them at the next rising edge
      do begin
         @(negedge ref_clk);
         rdy = pready;
         r = prdata;
         e = pslverr;
         n++;
         @(posedge ref_clk);
      end while (rdy !== 1'b1 && n < 40);
      if (rdy !== 1'b1) fail_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask
   // operation write, then wait for the sequencer to go idle
   task automatic op(input crs_pkg::crs_op_t c, input logic [7:0] d, input logic [15:0] a);
      logic [31:0] r;
      logic        e;
      int          n;
      n = 0;
      apb(1'b1, crs_pkg::ADR_OPER, {a, d, 3'h0, c}, r, e);
      do begin
         apb(1'b0, crs_pkg::ADR_STAT, 32'h0, r, e);
         n++;
      end while (r[3] !== 1'b0 && n < 20);
      if (r[3] !== 1'b0) fail_count++;
   endtask
   task automatic arith(input logic [7:0] f, a, input crs_pkg::crs_op_t c,
                        input logic [7:0] d, ea, ef);
      wr(crs_pkg::ADR_FLAG, f);
      wr(crs_pkg::ADR_ACC, a);
      op(c, d, 16'h0000);
      rdc(crs_pkg::ADR_ACC, {24'h0, ea});
      rdc(crs_pkg::ADR_FLAG, {24'h0, ef});
   endtask
   // =====================================================
   // scenarios
   task automatic t_index();
      wr(crs_pkg::ADR_XR, 8'h10);
      op(crs_pkg::OP_EAX, 8'h00, 16'h1234);
      chk({16'h0, eff_addr}, 32'h1244);
      wr(crs_pkg::ADR_YR, 8'hF0);
      op(crs_pkg::OP_EAY, 8'h00, 16'h00FF);
      rdc(crs_pkg::ADR_EFF, 32'h01EF);
      op(crs_pkg::OP_CPX, 8'h10, 16'h0000);
      rdc(crs_pkg::ADR_FLAG, 32'h0B);
      wr(crs_pkg::ADR_FLAG, 8'h00);
      wr(crs_pkg::ADR_XR, 8'hFF);
      op(crs_pkg::OP_INX, 8'h00, 16'h0000);
      rdc(crs_pkg::ADR_XR, 32'h00);
      rdc(crs_pkg::ADR_FLAG, 32'h02);
      op(crs_pkg::OP_TXS, 8'h00, 16'h0000);
      rdc(crs_pkg::ADR_STK, 32'h00);
   endtask
   task automatic t_stack();
      wr(crs_pkg::ADR_STK, 8'hFF);
      wr(crs_pkg::ADR_FETCH, 8'h34);
      op(crs_pkg::OP_STEP, 8'h0C, 16'h0000);
      op(crs_pkg::OP_CALL, 8'h00, 16'h4000);
      chk({24'h0, u_mem.mem_ff[8'hFE]}, 32'h40);
      chk({16'h0, fetch_ptr}, 32'h4000);
      rdc(crs_pkg::ADR_STK, 32'hFD);
      wr(crs_pkg::ADR_FLAG, 8'hC3);
      op(crs_pkg::OP_PSHF, 8'h00, 16'h0000);
      chk({24'h0, u_mem.mem_ff[8'hFD]}, 32'hC3);
      rdc(crs_pkg::ADR_STK, 32'hFC);
      wr(crs_pkg::ADR_FLAG, 8'h00);
      op(crs_pkg::OP_PULF, 8'h00, 16'h0000);
      rdc(crs_pkg::ADR_FLAG, 32'hC3);
      rdc(crs_pkg::ADR_STK, 32'hFD);
   endtask
   task automatic t_int();
      int n0;
      n0 = n_int;
      wr(crs_pkg::ADR_FLAG, 8'h04);
      irq_req <= 1'b1;
      repeat (10) @(posedge ref_clk);
      chk(n_int - n0, 32'h0);
      wr(crs_pkg::ADR_FLAG, 8'h00);
      repeat (12) @(posedge ref_clk);
      irq_req <= 1'b0;
      chk(n_int - n0, 32'h1);
      chk({16'h0, fetch_ptr}, 32'hFFFE);
      rdc(crs_pkg::ADR_FLAG, 32'h04);
      nmi_req <= 1'b1;
      repeat (12) @(posedge ref_clk);
      nmi_req <= 1'b0;
      chk(n_int - n0, 32'h2);
      chk({16'h0, fetch_ptr}, 32'hFFFA);
   endtask
   // =====================================================
   // main sequence
   initial begin
      logic [31:0] r;
      logic        e;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      rdc(crs_pkg::ADR_FETCH, 32'hFFFC);
      rdc(crs_pkg::ADR_STK, 32'hFF);
      rdc(crs_pkg::ADR_FLAG, 32'h34);
      rdc(crs_pkg::ADR_ACC, 32'h00);
      arith(8'h00, 8'h50, crs_pkg::OP_ADC, 8'h50, 8'hA0, 8'hC0);
      arith(8'h01, 8'h80, crs_pkg::OP_SBC, 8'h01, 8'h7F, 8'h41);
      arith(8'h01, 8'h10, crs_pkg::OP_SBC, 8'h10, 8'h00, 8'h03);
      arith(8'h08, 8'h19, crs_pkg::OP_ADC, 8'h01, 8'h20, 8'h08);
      arith(8'h00, 8'h81, crs_pkg::OP_ASL, 8'h00, 8'h02, 8'h01);
      arith(8'h01, 8'h02, crs_pkg::OP_ROR, 8'h00, 8'h81, 8'h80);
      arith(8'h00, 8'h00, crs_pkg::OP_LDA, 8'h80, 8'h80, 8'h80);
      arith(8'h00, 8'h80, crs_pkg::OP_TAY, 8'h00, 8'h80, 8'h80);
      arith(8'h00, 8'h11, crs_pkg::OP_CPY, 8'h80, 8'h11, 8'h03);
      arith(8'h00, 8'h11, crs_pkg::OP_FSET, 8'h09, 8'h11, 8'h00);
      op(crs_pkg::OP_FSET, 8'h09, 16'h0009);
      op(crs_pkg::OP_NOP, 8'h00, 16'h0000);
      rdc(crs_pkg::ADR_FLAG, 32'h09);
      t_index();
      t_stack();
      t_int();
      apb(1'b0, 8'h40, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      rst_b <= 1'b0;
      @(posedge ref_clk);
      chk({16'h0, fetch_ptr}, 32'hFFFC);
      complete_run();
   end
endmodule
bind crs_core_regs crs_regs_sva u_sva (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .irq_req, .nmi_req, .int_taken, .stk_we, .stk_re,
   .stk_addr, .stk_wdata, .stk_rdata, .fetch_ptr, .eff_addr);
`default_nettype wire
